// ---- hw/jdp_debug_port.sv ----
// debug signal port top: test clock logic, debug event pin, address trace
`timescale 1ns/1ns
`default_nettype none
// How it works
// - tms sampled each rising tck edge
// - tdi sampled rising edge, lsb first
// - tdo driven only in shift states
// - tdo changes on falling tck edge
// - shifted out least significant bit first
// - trst_b resets controller asynchronously
// - five tms ones reach reset state
// - test resets never reset core, but trst_b clearing a set request toggle reaches core as a request
// - debug event pin open drain, wired
// - request: finish instruction, save, enter debug
// - acknowledge pin low three clocks
// - address trace mirrors internal accesses
// - ir output idcode in reset state
// - capture ir loads status and 01
module jdp_debug_port
  import jdp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              tck,
  input  wire logic              trst_b,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdoOe,
  input  wire logic              debug_event_n_in,
  output logic                   debug_event_n_out,
  output logic                   debug_event_n_oe,
  input  wire logic              breakpointHit,
  input  wire logic              instrDone,
  input  wire logic              addr_trace_enable,
  input  wire logic              intAccValid,
  input  wire logic [ADDR_W-1:0] intAccAddr,
  input  wire logic [ADDR_W-1:0] extAddr,
  output logic [ADDR_W-1:0]      addrOut,
  output logic                   pipeSave,
  output logic                   debugMode
);
  typedef enum logic [1:0] {CORE_RUN, CORE_FINISH, CORE_DEBUG} jdp_core_state_t;

  jdp_xfer_if xfer ();

  jdp_core_state_t  coreStateFf;
  logic [2:0]       reqSyncFf;
  logic [1:0]       pinSyncFf;
  logic             pinPrevFf;
  logic [1:0]       ackCntFf;
  logic [1:0]       statSyncFf [2];
  logic             pinReq;
  logic             tapReq;
  logic             enterDbg;
  logic [1:0]       statSrcFf;

  // the test port has no link into core reset
  jdp_tap_ctrl u_tap (
    .tck    (tck),
    .trst_b (trst_b),
    .tms    (tms),
    .tdi    (tdi),
    .tdo    (tdo),
    .tdoOe  (tdoOe),
    .xfer   (xfer.tap)
  );

  // debug event pin and toggle each pass two flops first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqSyncFf <= '0;
      pinSyncFf <= 2'h3;
      pinPrevFf <= 1'b1;
    end else begin
      reqSyncFf <= {reqSyncFf[1:0], xfer.dbgReqTgl};
      pinSyncFf <= {pinSyncFf[0], debug_event_n_in};
      pinPrevFf <= pinSyncFf[1];
    end
  end

  // own acknowledge is ignored as a request while driving
  assign pinReq = !pinSyncFf[1] && pinPrevFf && (ackCntFf == 2'h0);
  assign tapReq = reqSyncFf[2] ^ reqSyncFf[1];

  // oe must rise with debugMode, not a cycle after pipeSave
  assign enterDbg = ((coreStateFf == CORE_RUN) && breakpointHit) ||
                    ((coreStateFf == CORE_FINISH) && instrDone);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      coreStateFf <= CORE_RUN;
      pipeSave    <= 1'b0;
      debugMode   <= 1'b0;
    end else begin
      pipeSave <= 1'b0;
      case (coreStateFf)
        CORE_RUN: begin
          if (breakpointHit) begin
            coreStateFf <= CORE_DEBUG;
            pipeSave    <= 1'b1;
            debugMode   <= 1'b1;
          end else if (pinReq || tapReq) begin
            coreStateFf <= CORE_FINISH;
          end
        end
        CORE_FINISH: begin
          if (instrDone) begin
            coreStateFf <= CORE_DEBUG;
            pipeSave    <= 1'b1;
            debugMode   <= 1'b1;
          end
        end
        CORE_DEBUG: begin
          // debug state holds here; only system reset leaves it
          coreStateFf <= CORE_DEBUG;
        end
        default: coreStateFf <= CORE_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackCntFf          <= 2'h0;
      debug_event_n_out <= 1'b0;
      debug_event_n_oe  <= 1'b0;
    end else begin
      if (enterDbg) begin
        ackCntFf <= ACK_CNT_W1;
      end else if (ackCntFf != 2'h0) begin
        ackCntFf <= ackCntFf - 2'h1;
      end
      debug_event_n_out <= 1'b0;
      debug_event_n_oe  <= enterDbg || (ackCntFf > 2'h1);
    end
  end

  // status launched from a flop so the tck side never sees decode glitches
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      statSrcFf <= 2'h0;
    end else begin
      statSrcFf <= {coreStateFf == CORE_DEBUG, coreStateFf == CORE_FINISH};
    end
  end

  // core status: bit1 debug, bit0 finishing
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      statSyncFf[0] <= '0;
      statSyncFf[1] <= '0;
    end else begin
      statSyncFf[0] <= statSrcFf;
      statSyncFf[1] <= statSyncFf[0];
    end
  end
  assign xfer.coreStatus = statSyncFf[1];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addrOut <= '0;
    end else begin
      addrOut <= (addr_trace_enable && intAccValid) ? intAccAddr : extAddr;
    end
  end

  a_ack_three: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(debugMode) |-> debug_event_n_oe [*3] ##1 !debug_event_n_oe)
    else $error("acknowledge not three cycles");
  a_finish_first: assert property (@(posedge ref_clk) disable iff (!rst_b)
    coreStateFf == CORE_FINISH && !instrDone |=> !debugMode)
    else $error("debug entered before instruction end");
  a_trace_addr: assert property (@(posedge ref_clk) disable iff (!rst_b)
    addr_trace_enable && intAccValid |=> addrOut == $past(intAccAddr))
    else $error("trace address not shown");
  a_pin_drives_low: assert property (@(posedge ref_clk) disable iff (!rst_b)
    debug_event_n_oe |-> !debug_event_n_out)
    else $error("debug pin driven high");
  a_trst_core: assert property (@(posedge ref_clk) disable iff (!rst_b)
    debugMode |=> debugMode)
    else $error("debug state lost without system reset");
endmodule : jdp_debug_port
`default_nettype wire

// ---- hw/jdp_pkg.sv ----
// shared constants and types for the debug signal port
package jdp_pkg;
  localparam int          IR_W          = 4;
  localparam logic [3:0]  IR_RESET_VAL  = 4'h2;
  localparam logic [1:0]  IR_CAPT_LOW   = 2'h1;
  localparam logic [3:0]  IR_DEBUG_REQ  = 4'h7;
  localparam logic [3:0]  IR_ENABLE_UNIT = 4'h6;
  localparam int          TMS_RESET_ONES = 5;
  localparam int          ACK_CYCLES    = 3;
  localparam logic [1:0]  ACK_CNT_W1    = 2'h3;
  localparam int          ADDR_W        = 24;
  localparam int          DR_W          = 32;
  localparam logic [31:0] ID_VALUE      = 32'h0000_0001;
  localparam int          FINISH_CYCLES = 2;

  typedef enum logic [3:0] {
    TST_RESET, TST_IDLE, TST_SEL_DR, TST_CAP_DR, TST_SHIFT_DR, TST_EXIT1_DR,
    TST_PAUSE_DR, TST_EXIT2_DR, TST_UPD_DR, TST_SEL_IR, TST_CAP_IR, TST_SHIFT_IR,
    TST_EXIT1_IR, TST_PAUSE_IR, TST_EXIT2_IR, TST_UPD_IR
  } jdp_tap_state_t;
endpackage : jdp_pkg

// ---- hw/jdp_tap_ctrl.sv ----
// test clock side: state machine, instruction and data shift paths
`timescale 1ns/1ns
`default_nettype none
module jdp_tap_ctrl
  import jdp_pkg::*;
(
  input  wire logic tck,
  input  wire logic trst_b,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo,
  output logic      tdoOe,
  jdp_xfer_if.tap   xfer
);
  jdp_tap_state_t   stateFf;
  jdp_tap_state_t   nxtState;
  logic [IR_W-1:0]  irShiftFf;
  logic [IR_W-1:0]  irOutFf;
  logic [DR_W-1:0]  drShiftFf;
  logic             reqTglFf;

  always_comb begin
    case (stateFf)
      TST_RESET:    nxtState = tms ? TST_RESET : TST_IDLE;
      TST_IDLE:     nxtState = tms ? TST_SEL_DR : TST_IDLE;
      TST_SEL_DR:   nxtState = tms ? TST_SEL_IR : TST_CAP_DR;
      TST_CAP_DR:   nxtState = tms ? TST_EXIT1_DR : TST_SHIFT_DR;
      TST_SHIFT_DR: nxtState = tms ? TST_EXIT1_DR : TST_SHIFT_DR;
      TST_EXIT1_DR: nxtState = tms ? TST_UPD_DR : TST_PAUSE_DR;
      TST_PAUSE_DR: nxtState = tms ? TST_EXIT2_DR : TST_PAUSE_DR;
      TST_EXIT2_DR: nxtState = tms ? TST_UPD_DR : TST_SHIFT_DR;
      TST_UPD_DR:   nxtState = tms ? TST_SEL_DR : TST_IDLE;
      TST_SEL_IR:   nxtState = tms ? TST_RESET : TST_CAP_IR;
      TST_CAP_IR:   nxtState = tms ? TST_EXIT1_IR : TST_SHIFT_IR;
      TST_SHIFT_IR: nxtState = tms ? TST_EXIT1_IR : TST_SHIFT_IR;
      TST_EXIT1_IR: nxtState = tms ? TST_UPD_IR : TST_PAUSE_IR;
      TST_PAUSE_IR: nxtState = tms ? TST_EXIT2_IR : TST_PAUSE_IR;
      TST_EXIT2_IR: nxtState = tms ? TST_UPD_IR : TST_SHIFT_IR;
      TST_UPD_IR:   nxtState = tms ? TST_SEL_DR : TST_IDLE;
      default:      nxtState = TST_RESET;
    endcase
  end

  // graph gives reset from any state after five ones
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      stateFf <= TST_RESET;
    end else begin
      stateFf <= nxtState;
    end
  end

  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      irShiftFf <= IR_RESET_VAL;
      irOutFf   <= IR_RESET_VAL;
    end else begin
      if (stateFf == TST_RESET) begin
        irOutFf <= IR_RESET_VAL;
      end else if (stateFf == TST_UPD_IR) begin
        irOutFf <= irShiftFf;
      end
      if (stateFf == TST_CAP_IR) begin
        irShiftFf <= {xfer.coreStatus, IR_CAPT_LOW};
      end else if (stateFf == TST_SHIFT_IR) begin
        irShiftFf <= {tdi, irShiftFf[IR_W-1:1]};
      end
    end
  end

  // idcode for ir 0010, one-bit path otherwise
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      drShiftFf <= '0;
    end else if (stateFf == TST_CAP_DR) begin
      drShiftFf <= (irOutFf == IR_RESET_VAL) ? ID_VALUE : '0;
    end else if (stateFf == TST_SHIFT_DR) begin
      if (irOutFf == IR_RESET_VAL) begin
        drShiftFf <= {tdi, drShiftFf[DR_W-1:1]};
      end else begin
        drShiftFf <= {{(DR_W-1){1'b0}}, tdi};
      end
    end
  end

  // debug request crosses as a toggle
  always_ff @(posedge tck or negedge trst_b) begin
    if (!trst_b) begin
      reqTglFf <= 1'b0;
    end else if (stateFf == TST_UPD_IR && irShiftFf == IR_DEBUG_REQ) begin
      reqTglFf <= ~reqTglFf;
    end
  end
  assign xfer.dbgReqTgl = reqTglFf;

  always_ff @(negedge tck or negedge trst_b) begin
    if (!trst_b) begin
      tdo   <= 1'b0;
      tdoOe <= 1'b0;
    end else begin
      tdoOe <= (stateFf == TST_SHIFT_IR) || (stateFf == TST_SHIFT_DR);
      tdo   <= (stateFf == TST_SHIFT_IR) ? irShiftFf[0] : drShiftFf[0];
    end
  end

  a_tdo_enable: assert property (@(posedge tck) disable iff (!trst_b)
    tdoOe == ((stateFf == TST_SHIFT_IR) || (stateFf == TST_SHIFT_DR)))
    else $error("tdo enable outside shift states");
  a_tms_five_reset: assert property (@(posedge tck) disable iff (!trst_b)
    tms [*5] |=> stateFf == TST_RESET)
    else $error("five tms ones did not reach reset");
  a_ir_reset_val: assert property (@(posedge tck) disable iff (!trst_b)
    stateFf == TST_RESET |=> irOutFf == IR_RESET_VAL)
    else $error("ir output not idcode in reset");
  a_ir_capture: assert property (@(posedge tck) disable iff (!trst_b)
    stateFf == TST_CAP_IR |=> irShiftFf[1:0] == IR_CAPT_LOW)
    else $error("capture ir low bits wrong");
  a_ir_shift_lsb: assert property (@(posedge tck) disable iff (!trst_b)
    stateFf == TST_SHIFT_IR |=> irShiftFf[IR_W-1] == $past(tdi))
    else $error("ir shift not lsb first");
  a_tms_sample: assert property (@(posedge tck) disable iff (!trst_b)
    stateFf == TST_IDLE && tms |=> stateFf == TST_SEL_DR)
    else $error("tms not sequencing state");
  a_tdo_lsb: assert property (@(negedge tck) disable iff (!trst_b)
    stateFf == TST_SHIFT_IR |=> tdo == $past(irShiftFf[0]))
    else $error("tdo not ir lsb");
endmodule : jdp_tap_ctrl
`default_nettype wire

// ---- hw/jdp_xfer_if.sv ----
// signals passed between the test clock logic and the core logic: request toggle to the core, core status back
`timescale 1ns/1ns
`default_nettype none
interface jdp_xfer_if;
  logic       dbgReqTgl;
  logic [1:0] coreStatus;
  modport tap  (output dbgReqTgl, input coreStatus);
  modport core (input dbgReqTgl, output coreStatus);
endinterface : jdp_xfer_if
`default_nettype wire

// ---- testbench/jdp_debug_port_tb_top.sv ----
// testbench top: scenarios for the debug signal port
`timescale 1ns/1ns
`default_nettype none
module jdp_debug_port_tb_top
  import jdp_pkg::*;
;
  logic              ref_clk, rst_b, trst_b, hostPull, breakpointHit, instrDone;
  logic              addr_trace_enable, intAccValid;
  logic [ADDR_W-1:0] intAccAddr, extAddr;
  wire logic         tck, tms, tdi, tdo, tdoOe, pinOut, pinOe, pinLine, pipeSave, debugMode;
  wire logic [ADDR_W-1:0] addrOut;
  int                fail_count, samples_checked;
  logic [31:0]       d;
  logic              oe;
  int                a;
  logic              s;
  // wired-low pin with pull-up
  assign pinLine = !((pinOe && !pinOut) || hostPull);
  jdp_debug_port u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .tck(tck), .trst_b(trst_b), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoOe(tdoOe), .debug_event_n_in(pinLine), .debug_event_n_out(pinOut),
    .debug_event_n_oe(pinOe), .breakpointHit(breakpointHit), .instrDone(instrDone),
    .addr_trace_enable(addr_trace_enable), .intAccValid(intAccValid), .intAccAddr(intAccAddr),
    .extAddr(extAddr), .addrOut(addrOut), .pipeSave(pipeSave), .debugMode(debugMode));
  jdp_jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic sysrst();
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    cyc(2);
  endtask : sysrst
  // fixed window: instrDone pulses every fourth cycle, acknowledge cycles counted
  task automatic wait_debug(output int ack, output logic saved);
    ack = 0;
    saved = 1'b0;
    for (int i = 0; i < 80; i++) begin
      @(posedge ref_clk);
      instrDone <= (i % 4 == 3);
      saved |= (pipeSave === 1'b1);
      ack += (pinOe === 1'b1 && pinLine === 1'b0);
    end
    instrDone <= 1'b0;
    if (debugMode !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask : wait_debug
  task automatic t_reset();
    chk(tdoOe, 1'b0);
    chk(pinLine, 1'b1);
    chk(debugMode, 1'b0);
  endtask : t_reset
  task automatic t_trace();
    intAccAddr <= 24'hABCDEF;
    extAddr    <= 24'h123456;
    for (int i = 0; i < 3; i++) begin
      addr_trace_enable <= (i != 2);
      intAccValid       <= (i != 1);
      cyc(2);
      chk(addrOut, (i == 0) ? 24'hABCDEF : 24'h123456);
    end
  endtask : t_trace
  task automatic t_serial();
    trst_b <= 1'b0;
    cyc(2);
    trst_b <= 1'b1;
    cyc(2);
    u_host.scan(1'b0, 32'h0, 32, d, oe);
    chk(d, ID_VALUE);
    chk(oe, 1'b1);
    chk(tdoOe, 1'b0);
    u_host.scan(1'b1, 32'hF, 4, d, oe);
    chk(d[3:0], 4'h1);
    u_host.scan(1'b0, 32'h1, 2, d, oe);
    chk(d[1:0], 2'h2);
    u_host.reset5();
    u_host.scan(1'b0, 32'h0, 32, d, oe);
    chk(d, ID_VALUE);
  endtask : t_serial
  task automatic t_pin();
    hostPull <= 1'b1;
    cyc(2);
    hostPull <= 1'b0;
    wait_debug(a, s);
    chk(a, ACK_CYCLES);
    chk(s, 1'b1);
    trst_b <= 1'b0;
    cyc(2);
    trst_b <= 1'b1;
    cyc(2);
    chk(debugMode, 1'b1);
    u_host.scan(1'b1, 32'h2, 4, d, oe);
    chk(d[3:0], 4'h9);
  endtask : t_pin
  task automatic t_bkpt();
    sysrst();
    chk(debugMode, 1'b0);
    breakpointHit <= 1'b1;
    cyc(1);
    breakpointHit <= 1'b0;
    wait_debug(a, s);
    chk(a, ACK_CYCLES);
  endtask : t_bkpt
  task automatic t_ireq();
    sysrst();
    u_host.scan(1'b1, {28'h0, IR_DEBUG_REQ}, 4, d, oe);
    wait_debug(a, s);
    chk(a, ACK_CYCLES);
    chk(s, 1'b1);
  endtask : t_ireq
  initial begin
    rst_b = 1'b0;
    trst_b = 1'b0;
    hostPull = 1'b0;
    breakpointHit = 1'b0;
    instrDone = 1'b0;
    addr_trace_enable = 1'b0;
    intAccValid = 1'b0;
    intAccAddr = '0;
    extAddr = '0;
    fail_count = 0;
    samples_checked = 0;
    cyc(3);
    rst_b <= 1'b1;
    trst_b <= 1'b1;
    cyc(2);
    t_reset();
    t_trace();
    t_serial();
    t_pin();
    t_bkpt();
    t_ireq();
    complete_run();
  end
endmodule : jdp_debug_port_tb_top
`default_nettype wire

// ---- testbench/jdp_jtag_host.sv ----
// partner model: external test controller on the serial port
`timescale 1ns/1ns
`default_nettype none
module jdp_jtag_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdoOe
);
  // clock stands low between frames; tms/tdi start at their pull-up level, tms rests low after each frame
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // set while tck low, tdo taken just before the rising edge
  task automatic pulse(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    #6;
    q  = tdo;
    oe = tdoOe;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask : pulse
  task automatic reset5();
    logic q;
    logic oe;
    repeat (5) pulse(1'b1, 1'b1, q, oe);
    pulse(1'b0, 1'b1, q, oe);
  endtask : reset5
  // all ir and dr scans go through this scan path
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] dout, output logic oeAll);
    logic q;
    logic oe;
    dout  = '0;
    oeAll = 1'b1;
    // one low tms first: leaves test-logic-reset, stays in idle otherwise
    pulse(1'b0, 1'b1, q, oe);
    pulse(1'b1, 1'b1, q, oe);
    if (ir) pulse(1'b1, 1'b1, q, oe);
    pulse(1'b0, 1'b1, q, oe);
    pulse(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oeAll &= oe;
    end
    pulse(1'b1, 1'b1, q, oe);
    pulse(1'b0, 1'b1, q, oe);
    tdi = 1'b1;
  endtask : scan
endmodule : jdp_jtag_host
`default_nettype wire
